//--- oag_cfg.svh
// constants for the operand address generator
`ifndef OAG_CFG_SVH
`define OAG_CFG_SVH
// ---------------------------------------------------------------
// data space map
// ---------------------------------------------------------------
`define OAG_IO_DATA_OFS 16'h0020
`define OAG_SRAM_BASE 16'h0060
`define OAG_BIT_IO_LAST 6'h1F
// ---------------------------------------------------------------
// pointer pairs and reset values
// ---------------------------------------------------------------
`define OAG_PTR_BASE_REG 5'h1A
`define OAG_PC_RESET 16'h0000
`define OAG_PTR_STEP 16'h0001
`endif

//--- oag_pkg.sv
// types shared by the operand address generator and its users
`default_nettype none
package oag_pkg;
  // addressing mode chosen by the decoder
  typedef enum logic [4:0] {
    M_NONE, M_REG1, M_REG2, M_IO_DIR, M_DATA_DIR, M_IND, M_IND_DISP,
    M_IND_PREDEC, M_IND_POSTINC, M_PROG_CONST, M_INDIRECT_JUMP,
    M_INDIRECT_CALL, M_RELATIVE_JUMP, M_RELATIVE_CALL, M_SET_IO_BIT,
    M_CLEAR_IO_BIT, M_SKIP_IF_IO_BIT_SET, M_SKIP_IF_IO_BIT_CLEAR
  } mode_e;
  // pointer pair select
  typedef enum logic [1:0] {PTR_A, PTR_B, PTR_C} ptr_sel_e;
  // region of the data space hit by an address
  typedef enum logic [1:0] {RGN_REG, RGN_IO, RGN_SRAM} region_e;
  // one decoded instruction
  typedef struct packed {
    logic valid;
    mode_e mode;
    logic store;
    logic [4:0] rd;
    logic [4:0] rr;
    logic [5:0] io_num;
    logic [2:0] bit_idx;
    logic [5:0] disp;
    ptr_sel_e ptr_sel;
    logic [15:0] word2;
    logic [11:0] rel_k;
  } dec_req_s;
  // current pointer pair contents from the register file
  typedef struct packed {
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] c;
  } ptr_set_s;
  // everything the block drives toward memories and registers
  typedef struct packed {
    logic [4:0] rd_sel;
    logic [4:0] rr_sel;
    logic rf_we;
    logic [15:0] data_addr;
    region_e region;
    logic data_rd;
    logic data_wr;
    logic [5:0] io_addr;
    logic io_rd;
    logic io_wr;
    logic [7:0] io_wdata;
    logic ptr_we;
    logic [4:0] ptr_lo_reg;
    logic [15:0] ptr_val;
    logic prog_rd;
    logic [14:0] prog_word;
    logic prog_byte_hi;
    logic [15:0] pc;
    logic [15:0] fetch_addr;
    logic skip;
    logic bit_refused;
    logic busy;
  } oag_out_s;
endpackage : oag_pkg
`default_nettype wire

//--- operand_address_generator.sv
// operand, data and branch address generation for the 8-bit core
`default_nettype none
`include "oag_cfg.svh"
module operand_address_generator
  import oag_pkg::*;
(
  input wire logic clk_sys_i,      // system clock, undivided
  input wire logic rst_i,          // async reset, active high
  input var dec_req_s req_i,       // decoded instruction
  input var ptr_set_s ptr_i,       // pointer pairs from registers
  input wire logic [7:0] io_rdata_i, // I/O read data, next cycle
  output var oag_out_s out_o       // registered address outputs
);

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  typedef enum logic [1:0] {ST_EXEC, ST_DATA, ST_IO_BIT} state_e;

  typedef struct packed {
    state_e st;
    mode_e bit_mode;
    logic [2:0] bit_idx;
    oag_out_s o;
  } oag_state_s;

  oag_state_s cur;
  oag_state_s next_cur;

  // data space region decode
  function automatic region_e region_of(input logic [15:0] a);
    if (a < `OAG_IO_DATA_OFS) begin
      region_of = RGN_REG;
    end else if (a < `OAG_SRAM_BASE) begin
      region_of = RGN_IO;
    end else begin
      region_of = RGN_SRAM;
    end
  endfunction : region_of

  // pointer value selected by the request
  function automatic logic [15:0] ptr_of(input ptr_set_s p,
                                         input ptr_sel_e s);
    case (s)
      PTR_A: ptr_of = p.a;
      PTR_B: ptr_of = p.b;
      default: ptr_of = p.c;
    endcase
  endfunction : ptr_of

  logic [15:0] sel_ptr;
  logic [15:0] ptr_dec;
  logic [15:0] ptr_inc;
  logic [15:0] disp_addr;
  logic [15:0] rel_target;
  logic [15:0] pc_inc;
  logic [7:0] bit_mask;
  logic bit_val;

  // -------------------------------------------------------------
  // address arithmetic
  // -------------------------------------------------------------
  // all sums are 16 bits wide so they wrap around the space
  always_comb begin
    sel_ptr = ptr_of(ptr_i, req_i.ptr_sel);
    ptr_dec = sel_ptr - `OAG_PTR_STEP;
    ptr_inc = sel_ptr + `OAG_PTR_STEP;
    disp_addr = sel_ptr + {10'h000, req_i.disp};
    rel_target = cur.o.pc + {{4{req_i.rel_k[11]}}, req_i.rel_k}
                 + `OAG_PTR_STEP;
    pc_inc = cur.o.pc + `OAG_PTR_STEP;
    bit_mask = 8'h01 << cur.bit_idx;
    bit_val = |(io_rdata_i & bit_mask);
  end

  // -------------------------------------------------------------
  // next state
  // -------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    // strobes last one cycle unless a phase holds them
    next_cur.o.rf_we = 1'b0;
    next_cur.o.io_rd = 1'b0;
    next_cur.o.io_wr = 1'b0;
    next_cur.o.ptr_we = 1'b0;
    next_cur.o.prog_rd = 1'b0;
    next_cur.o.skip = 1'b0;
    next_cur.o.bit_refused = 1'b0;
    next_cur.o.data_rd = 1'b0;
    next_cur.o.data_wr = 1'b0;
    next_cur.o.busy = 1'b0;
    case (cur.st)
      ST_EXEC: begin
        if (req_i.valid) begin
          // the fetch address runs one word ahead of execution
          next_cur.o.pc = pc_inc;
          next_cur.o.rd_sel = req_i.rd;
          next_cur.o.rr_sel = req_i.rr;
          case (req_i.mode)
            M_REG1: begin
              next_cur.o.rf_we = 1'b1;
            end
            M_REG2: begin
              // both operands and write-back in this cycle
              next_cur.o.rf_we = 1'b1;
            end
            M_IO_DIR: begin
              next_cur.o.io_addr = req_i.io_num;
              next_cur.o.io_rd = ~req_i.store;
              next_cur.o.io_wr = req_i.store;
              next_cur.o.rf_we = ~req_i.store;
            end
            M_DATA_DIR, M_IND, M_IND_DISP, M_IND_PREDEC,
            M_IND_POSTINC: begin
              case (req_i.mode)
                M_DATA_DIR: next_cur.o.data_addr = req_i.word2;
                M_IND_DISP: next_cur.o.data_addr = disp_addr;
                M_IND_PREDEC: next_cur.o.data_addr = ptr_dec;
                default: next_cur.o.data_addr = sel_ptr;
              endcase
              if (req_i.mode == M_DATA_DIR) begin
                next_cur.o.pc = pc_inc + `OAG_PTR_STEP;
              end
              // pointer update goes back to its register pair
              if (req_i.mode == M_IND_PREDEC ||
                  req_i.mode == M_IND_POSTINC) begin
                next_cur.o.ptr_we = 1'b1;
                next_cur.o.ptr_lo_reg = `OAG_PTR_BASE_REG
                  + {2'b00, req_i.ptr_sel, 1'b0};
                next_cur.o.ptr_val = (req_i.mode == M_IND_PREDEC) ?
                  ptr_dec : ptr_inc;
              end
              next_cur.o.data_rd = ~req_i.store;
              next_cur.o.data_wr = req_i.store;
              next_cur.o.busy = 1'b1;
              next_cur.st = ST_DATA;
            end
            M_PROG_CONST: begin
              next_cur.o.prog_word = ptr_i.c[15:1];
              next_cur.o.prog_byte_hi = ptr_i.c[0];
              next_cur.o.prog_rd = 1'b1;
            end
            M_INDIRECT_JUMP, M_INDIRECT_CALL: begin
              next_cur.o.pc = ptr_i.c;
            end
            M_RELATIVE_JUMP, M_RELATIVE_CALL: begin
              next_cur.o.pc = rel_target;
            end
            M_SET_IO_BIT, M_CLEAR_IO_BIT, M_SKIP_IF_IO_BIT_SET,
            M_SKIP_IF_IO_BIT_CLEAR: begin
              if (req_i.io_num > `OAG_BIT_IO_LAST) begin
                next_cur.o.bit_refused = 1'b1;
              end else begin
                // read the whole register, modify or test the bit in the next cycle
                next_cur.o.io_addr = req_i.io_num;
                next_cur.o.io_rd = 1'b1;
                next_cur.o.busy = 1'b1;
                next_cur.bit_mode = req_i.mode;
                next_cur.bit_idx = req_i.bit_idx;
                next_cur.st = ST_IO_BIT;
              end
            end
            default: begin
              next_cur.o.rf_we = 1'b0;
            end
          endcase
          next_cur.o.fetch_addr = next_cur.o.pc;
        end
      end
      ST_DATA: begin
        // second cycle of the access; address still stands
        next_cur.o.data_rd = cur.o.data_rd;
        next_cur.o.data_wr = cur.o.data_wr;
        next_cur.o.rf_we = cur.o.data_rd;
        next_cur.st = ST_EXEC;
      end
      ST_IO_BIT: begin
        case (cur.bit_mode)
          // flags read as one are written back as one and clear
          M_SET_IO_BIT: begin
            next_cur.o.io_wdata = io_rdata_i | bit_mask;
            next_cur.o.io_wr = 1'b1;
          end
          M_CLEAR_IO_BIT: begin
            next_cur.o.io_wdata = io_rdata_i & ~bit_mask;
            next_cur.o.io_wr = 1'b1;
          end
          M_SKIP_IF_IO_BIT_SET: begin
            next_cur.o.skip = bit_val;
          end
          default: begin
            next_cur.o.skip = ~bit_val;
          end
        endcase
        next_cur.st = ST_EXEC;
      end
      default: begin
        next_cur.st = ST_EXEC;
      end
    endcase
    // region of the data address, I/O mapped above the registers
    next_cur.o.region = region_of(next_cur.o.data_addr);
  end

  // -------------------------------------------------------------
  // state register on the undivided system clock
  // -------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cur <= '0;
      cur.st <= ST_EXEC;
      cur.bit_mode <= M_NONE;
      cur.o.pc <= `OAG_PC_RESET;
      cur.o.fetch_addr <= `OAG_PC_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  // all outputs come straight from the state flops
  assign out_o = cur.o;

endmodule : operand_address_generator
`default_nettype wire

//--- oag_chk.sv
// checker: address and timing relations at the generator ports
`default_nettype none
`include "oag_cfg.svh"
module oag_chk
  import oag_pkg::*;
(
  input wire logic clk_sys_i, // system clock
  input wire logic rst_i, // async reset
  input var dec_req_s req_i, // decoded request
  input var ptr_set_s ptr_i, // pointer pairs
  input wire logic [7:0] io_rdata_i, // I/O read data
  input var oag_out_s out_o // generator outputs
);
  logic [15:0] pv;
  logic [15:0] rk;
  mode_e m;
  logic dx;
  // taken mode, selected pointer, sign-extended offset
  assign m = (req_i.valid && !out_o.busy) ? req_i.mode : M_NONE;
  assign pv = req_i.ptr_sel == PTR_A ? ptr_i.a :
    req_i.ptr_sel == PTR_B ? ptr_i.b : ptr_i.c;
  assign rk = {{4{req_i.rel_k[11]}}, req_i.rel_k};
  assign dx = out_o.data_rd || out_o.data_wr;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  property p_pre;
    m == M_IND_PREDEC |=> out_o.ptr_we &&
      out_o.data_addr == $past(pv) - 16'h0001 &&
      out_o.ptr_val == out_o.data_addr;
  endproperty
  a_pre: assert property (p_pre) else $error("predecrement");
  property p_post;
    m == M_IND_POSTINC |=> out_o.ptr_we && out_o.data_addr == $past(pv)
      && out_o.ptr_val == $past(pv) + 16'h0001 &&
      out_o.ptr_lo_reg == 5'h1A + {2'h0, $past(req_i.ptr_sel), 1'b0};
  endproperty
  a_post: assert property (p_post) else $error("postinc");
  property p_dd;
    m == M_DATA_DIR |=> dx && out_o.data_addr == $past(req_i.word2) ##1 dx;
  endproperty
  a_dd: assert property (p_dd) else $error("data direct");
  property p_rgn;
    dx |-> out_o.region == (out_o.data_addr < `OAG_IO_DATA_OFS ? RGN_REG :
      out_o.data_addr < `OAG_SRAM_BASE ? RGN_IO : RGN_SRAM);
  endproperty
  a_rgn: assert property (p_rgn) else $error("region");
  property p_prog;
    m == M_PROG_CONST |=> out_o.prog_rd &&
      {out_o.prog_word, out_o.prog_byte_hi} == $past(ptr_i.c);
  endproperty
  a_prog: assert property (p_prog) else $error("constant");
  property p_indirect_jump;
    m == M_INDIRECT_JUMP || m == M_INDIRECT_CALL |=>
      out_o.pc == $past(ptr_i.c) && out_o.fetch_addr == out_o.pc;
  endproperty
  a_indirect_jump: assert property (p_indirect_jump) else $error("indirect");
  property p_rjmp;
    m == M_RELATIVE_JUMP || m == M_RELATIVE_CALL |=>
      out_o.pc == $past(out_o.pc) + $past(rk) + 16'h0001;
  endproperty
  a_rjmp: assert property (p_rjmp) else $error("relative");
  property p_bit;
    m == M_SET_IO_BIT && req_i.io_num <= `OAG_BIT_IO_LAST |=> out_o.io_rd
      && out_o.io_addr == $past(req_i.io_num) ##1 out_o.io_wr &&
      out_o.io_wdata == ($past(io_rdata_i) | 8'(8'h01 <<
      $past(req_i.bit_idx, 2)));
  endproperty
  a_bit: assert property (p_bit) else $error("bit set");
  property p_ref;
    (m == M_SET_IO_BIT || m == M_CLEAR_IO_BIT) &&
      req_i.io_num > `OAG_BIT_IO_LAST |=>
      out_o.bit_refused && !out_o.io_rd ##1 !out_o.io_wr;
  endproperty
  a_ref: assert property (p_ref) else $error("bit refuse");
  property p_skip;
    (m == M_SKIP_IF_IO_BIT_SET || m == M_SKIP_IF_IO_BIT_CLEAR) &&
      req_i.io_num <= `OAG_BIT_IO_LAST |=> out_o.io_rd && !out_o.skip
      ##1 !out_o.io_wr && out_o.skip == ((|($past(io_rdata_i) &
      8'(8'h01 << $past(req_i.bit_idx, 2)))) ==
      ($past(req_i.mode, 2) == M_SKIP_IF_IO_BIT_SET));
  endproperty
  a_skip: assert property (p_skip) else $error("bit skip");
  property p_reg;
    m == M_REG1 || m == M_REG2 |=> out_o.rf_we &&
      out_o.rd_sel == $past(req_i.rd);
  endproperty
  a_reg: assert property (p_reg) else $error("reg");
endmodule : oag_chk
`default_nettype wire

//--- oag_far_model.sv
// far-side model: pointer registers and I/O register space
`default_nettype none
module oag_far_model
  import oag_pkg::*;
(
  input wire logic clk_sys_i, // system clock
  input wire logic rst_i, // async reset
  input var oag_out_s out_i, // generator outputs
  output var ptr_set_s ptr_o, // pointer pairs
  output logic [7:0] io_rdata_o // I/O read data
);
  ptr_set_s ptr;
  logic [7:0] io [64];
  logic [7:0] last;
  assign ptr_o = ptr;
  // answer while io_rd, a changing pattern otherwise
  assign io_rdata_o = out_i.io_rd ? io[out_i.io_addr] : ~last;
  // register writes and pointer write-back
  always @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ptr <= '0;
      for (int i = 0; i < 64; i++) io[i] <= 8'(i * 37);
      last <= 8'h00;
    end else begin
      last <= io_rdata_o;
      if (out_i.io_wr) io[out_i.io_addr] <= out_i.io_wdata;
      case (out_i.ptr_we ? out_i.ptr_lo_reg : 5'h00)
        5'h1A: ptr.a <= out_i.ptr_val;
        5'h1C: ptr.b <= out_i.ptr_val;
        5'h1E: ptr.c <= out_i.ptr_val;
        default: ;
      endcase
    end
  end
endmodule : oag_far_model
`default_nettype wire

//--- tb_top.sv
// testbench: random addressing traffic against the far-side model
`default_nettype none
module tb_top
  import oag_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct packed {logic [2:0] k; logic [15:0] v;} exp_s;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  dec_req_s req = '0;
  ptr_set_s ptr;
  logic [7:0] io_rdata;
  oag_out_s out;
  exp_s q[$];
  exp_s e;
  logic [15:0] tp [3];
  logic [7:0] sh [64];
  logic [15:0] pc = 16'h0000;
  logic tkd = 1'b0;
  int n_mismatch = 0;
  int compares = 0;
  mode_e ml [17] = '{M_IND, M_IND_DISP, M_IND_PREDEC, M_IND_POSTINC,
    M_DATA_DIR, M_PROG_CONST, M_INDIRECT_JUMP, M_INDIRECT_CALL,
    M_RELATIVE_JUMP, M_RELATIVE_CALL, M_SET_IO_BIT, M_CLEAR_IO_BIT,
    M_IO_DIR, M_REG1, M_REG2, M_SKIP_IF_IO_BIT_SET,
    M_SKIP_IF_IO_BIT_CLEAR};
  operand_address_generator operand_address_generator_inst (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_i(req), .ptr_i(ptr),
    .io_rdata_i(io_rdata), .out_o(out));
  oag_far_model oag_far_model_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .out_i(out), .ptr_o(ptr), .io_rdata_o(io_rdata));
  // undivided system clock
  always #25 clk_sys_i = ~clk_sys_i;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict
  // one request with its expected result noted
  task automatic run(input mode_e m);
    dec_req_s r;
    logic [2:0] k;
    logic [15:0] x;
    r = dec_req_s'(62'({$urandom, $urandom}));
    r.valid = 1'b1;
    r.mode = m;
    r.ptr_sel = m == M_IND_DISP ? (r.store ? PTR_C : PTR_B) :
      ptr_sel_e'(2'(r.rd % 3));
    r.io_num[5] = 1'b0;
    if (m == M_IO_DIR) r.store = 1'b0;
    x = tp[r.ptr_sel];
    k = 3'd0;
    pc = pc + 16'h0001;
    case (m)
      M_IND_DISP: x = x + 16'(r.disp);
      M_IND_PREDEC: begin
        x = x - 16'h0001;
        tp[r.ptr_sel] = x;
      end
      M_IND_POSTINC: tp[r.ptr_sel] = x + 16'h0001;
      M_DATA_DIR: begin
        x = r.word2;
        pc = pc + 16'h0001;
      end
      M_PROG_CONST: {k, x} = {3'd2, tp[2]};
      M_INDIRECT_JUMP, M_INDIRECT_CALL: pc = tp[2];
      M_RELATIVE_JUMP, M_RELATIVE_CALL: pc = pc + 16'(signed'(r.rel_k));
      M_SET_IO_BIT: sh[r.io_num] = sh[r.io_num] | 8'(8'h01 << r.bit_idx);
      M_CLEAR_IO_BIT: sh[r.io_num] = sh[r.io_num] & ~8'(8'h01 << r.bit_idx);
      M_IO_DIR: {k, x} = {3'd4, 10'h000, r.io_num};
      default: k = 3'd7;
    endcase
    if (m inside {[M_INDIRECT_JUMP:M_RELATIVE_CALL]}) {k, x} = {3'd1, pc};
    if (m inside {M_SET_IO_BIT, M_CLEAR_IO_BIT})
      {k, x} = {3'd3, 8'h00, sh[r.io_num]};
    @(posedge clk_sys_i);
    req <= r;
    q.push_back({k, x});
    if (m inside {[M_IND:M_IND_POSTINC], M_DATA_DIR, M_SET_IO_BIT,
        M_CLEAR_IO_BIT, M_SKIP_IF_IO_BIT_SET,
        M_SKIP_IF_IO_BIT_CLEAR}) begin
      @(posedge clk_sys_i);
      req.mode <= M_RELATIVE_JUMP;
    end
  endtask : run
  // take the oldest note whenever a result shows
  always @(posedge clk_sys_i) begin
    if (tkd && q.size() > 0 && q[0].k != 3'd3) begin
      e = q.pop_front();
      case (e.k)
        3'd0: chk(out.data_addr, e.v);
        3'd1: chk(out.pc, e.v);
        3'd2: chk({out.prog_word, out.prog_byte_hi}, e.v);
        3'd4: chk({10'h000, out.io_addr}, e.v);
        default: ;
      endcase
    end
    if (out.io_wr && q.size() > 0) begin
      e = q.pop_front();
      chk({8'h00, out.io_wdata}, e.v);
    end
    tkd <= req.valid && !out.busy && !rst_i;
  end
  // main sequence
  initial begin
    void'($urandom(65476));
    for (int i = 0; i < 64; i++) sh[i] = 8'(i * 37);
    for (int i = 0; i < 3; i++) tp[i] = 16'($urandom);
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    @(posedge clk_sys_i);
    oag_far_model_inst.ptr <= {tp[0], tp[1], tp[2]};
    for (int i = 0; i < 300; i++) run(ml[i < 17 ? i : $urandom % 17]);
    @(posedge clk_sys_i);
    req.mode <= M_CLEAR_IO_BIT;
    req.io_num <= 6'h2A;
    req.valid <= 1'b1;
    @(posedge clk_sys_i);
    req.valid <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    give_verdict();
  end
  // watchdog
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    n_mismatch++;
    give_verdict();
  end
endmodule : tb_top
bind operand_address_generator oag_chk oag_chk_inst (.clk_sys_i(clk_sys_i),
  .rst_i(rst_i), .req_i(req_i), .ptr_i(ptr_i), .io_rdata_i(io_rdata_i),
  .out_o(out_o));
`default_nettype wire
